//--- lpddr_init_pkg.sv
// Shared constants, commands and register map for the init sequencer pair
package lpddr_init_pkg;

  // ------------------------------------------------------------
  // Clock and time conversion
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int TW      = 16;

  // Least time: round up, at least one cycle
  function automatic int ns_to_cyc_min(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  // Longest time: round down, at least one cycle
  function automatic int ns_to_cyc_max(input int ns);
    int c;
    c = (ns * CLK_MHZ) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  // ------------------------------------------------------------
  // Initialization times
  // ------------------------------------------------------------
  localparam int CKE_LOW_WAIT_NS          = 100;
  localparam int CKE_LOW_WAIT_CYC         = ns_to_cyc_min(CKE_LOW_WAIT_NS);
  localparam int STABLE_CLOCK_WAIT_TCK    = 5;
  localparam int FIRST_IDLE_WAIT_US       = 200;
  localparam int FIRST_IDLE_WAIT_CYC      = ns_to_cyc_min(FIRST_IDLE_WAIT_US * 1000);
  localparam int POST_RESET_WAIT_US       = 1;
  localparam int POST_RESET_WAIT_CYC      = ns_to_cyc_min(POST_RESET_WAIT_US * 1000);
  localparam int AUTO_INIT_MAX_TIME_US    = 10;
  localparam int AUTO_INIT_MAX_CYC        = ns_to_cyc_max(AUTO_INIT_MAX_TIME_US * 1000);
  localparam int INITIAL_CAL_TIME_US      = 1;
  localparam int INITIAL_CAL_CYC          = ns_to_cyc_min(INITIAL_CAL_TIME_US * 1000);
  localparam int BOOT_CLOCK_PERIOD_MIN_NS = 18;
  localparam int BOOT_CLOCK_PERIOD_MAX_NS = 100;
  localparam int BOOT_CMD_SPACING_CYC     = ns_to_cyc_min(BOOT_CLOCK_PERIOD_MIN_NS);
  localparam int AUTO_INIT_DONE_CYC       = 500;
  localparam int CLKUP_WAIT_CYC           = (CKE_LOW_WAIT_CYC > STABLE_CLOCK_WAIT_TCK) ?
                                            CKE_LOW_WAIT_CYC : STABLE_CLOCK_WAIT_TCK;

  // ------------------------------------------------------------
  // Commands and mode registers
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    CMD_NOP  = 2'h0,
    CMD_MRW  = 2'h1,
    CMD_MRR  = 2'h2,
    CMD_PREA = 2'h3
  } ca_cmd_t;

  localparam logic [7:0] MR_DEVICE_INFO  = 8'h00;
  localparam logic [7:0] MR_FEATURE1     = 8'h01;
  localparam logic [7:0] MR_FEATURE2     = 8'h02;
  localparam logic [7:0] MR_IO_CONFIG    = 8'h03;
  localparam logic [7:0] MR_CALIBRATION  = 8'h0A;
  localparam logic [7:0] MR_TERMINATION  = 8'h0B;
  localparam logic [7:0] MR_RESET        = 8'h3F;
  localparam int         AUTO_INIT_FLAG_BIT = 0;
  localparam int         TERM_ENABLE_BIT    = 0;
  localparam logic [7:0] CAL_INIT_CODE   = 8'hFF;

  // ------------------------------------------------------------
  // Controller register map
  // ------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_MRCFG     = 8'h04;
  localparam logic [7:0]  REG_STATUS    = 8'h08;
  localparam int          CTRL_START    = 0;
  localparam int          CTRL_TRAIN    = 1;
  localparam int          CTRL_TRAINED  = 2;
  localparam int          CTRL_PWROFF   = 3;
  localparam int          CTRL_POLL     = 4;
  localparam int          CTRL_TERMLVL  = 5;
  localparam int          CTRL_PREA     = 6;
  localparam logic [6:0]  CTRL_RST      = 7'h10;
  localparam logic [31:0] MRCFG_RST     = 32'h0000_0000;

endpackage

//--- lpddr_link_if.sv
// Command/address link between memory controller and memory device
interface lpddr_link_if;
  import lpddr_init_pkg::*;

  logic       ck_run;
  logic       cke;
  logic       term_ctl;
  logic       ca_oe;
  ca_cmd_t    ca_cmd;
  logic [7:0] ca_addr;
  logic [7:0] ca_op;
  logic [7:0] dq;
  logic       dq_oe;

  modport ctrl (
    output ck_run, cke, term_ctl, ca_oe, ca_cmd, ca_addr, ca_op,
    input  dq, dq_oe
  );

  modport mem (
    input  ck_run, cke, term_ctl, ca_oe, ca_cmd, ca_addr, ca_op,
    output dq, dq_oe
  );
endinterface

//--- lpddr_cycle_timer.sv
// Loadable down counter with registered expiry flag
module lpddr_cycle_timer #(
  parameter int W = 16
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_count,
  output logic              o_done
);
  logic [W-1:0] cnt_r;
  logic         done_r;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_r  <= '0;
      done_r <= 1'b1;
    end else if (i_load) begin
      cnt_r  <= i_count;
      done_r <= (i_count == '0);
    end else if (cnt_r != '0) begin
      cnt_r  <= cnt_r - 1'b1;
      done_r <= (cnt_r == {{(W-1){1'b0}}, 1'b1});
    end
  end

  assign o_done = done_r;
endmodule

//--- lpddr_init_mem.sv
// Memory-device end: reset, auto-initialization, calibration and termination state
module lpddr_init_mem #(
  parameter int AUTO_INIT_CYC = lpddr_init_pkg::AUTO_INIT_DONE_CYC
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  lpddr_link_if.mem       link,
  output logic            o_idle,
  output logic            o_ready,
  output logic            o_auto_init_flag,
  output logic            o_term_en,
  output logic            o_cmd_err,
  output logic [2:0]      o_state
);
  import lpddr_init_pkg::*;

  typedef enum logic [2:0] {
    D_OFF     = 3'h0,
    D_IDLE1   = 3'h1,
    D_POSTRST = 3'h3,
    D_AUTOINI = 3'h2,
    D_IDLE    = 3'h6,
    D_CAL     = 3'h7,
    D_READY   = 3'h5
  } dstate_t;

  dstate_t    st_r;
  dstate_t    st_nxt;
  logic       flag_r;
  logic       term_r;
  logic       err_r;
  logic       err_nxt;
  logic [7:0] dq_r;
  logic       dq_oe_r;
  logic       tmr_load;
  logic [TW-1:0] tmr_cnt;
  logic       tmr_done;
  logic       is_mrw;
  logic       is_mrr;
  logic       is_rst;
  logic       any_cmd;
  logic       idle_r;
  logic       ready_r;

  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  // Undriven bus reads as no operation
  assign any_cmd = link.cke && link.ca_oe && (link.ca_cmd != CMD_NOP);
  assign is_mrw  = any_cmd && (link.ca_cmd == CMD_MRW);
  assign is_mrr  = any_cmd && (link.ca_cmd == CMD_MRR);
  assign is_rst  = is_mrw && (link.ca_addr == MR_RESET);

  lpddr_cycle_timer #(.W(TW)) u_tmr (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_load  (tmr_load),
    .i_count (tmr_cnt),
    .o_done  (tmr_done)
  );

  // ------------------------------------------------------------
  // Sequence state
  // ------------------------------------------------------------
  always_comb begin
    st_nxt   = st_r;
    err_nxt  = 1'b0;
    tmr_load = 1'b0;
    tmr_cnt  = '0;
    if (is_rst) begin
      st_nxt   = D_POSTRST;
      tmr_load = 1'b1;
      tmr_cnt  = TW'(POST_RESET_WAIT_CYC);
    end else begin
      case (st_r)
        D_OFF: begin
          if (link.cke) begin
            st_nxt = D_IDLE1;
          end
        end
        D_IDLE1: begin
          if (!link.cke) begin
            st_nxt = D_OFF;
          end
          err_nxt = any_cmd && (link.ca_cmd != CMD_PREA);
        end
        D_POSTRST: begin
          err_nxt = any_cmd;
          if (tmr_done) begin
            st_nxt   = D_AUTOINI;
            tmr_load = 1'b1;
            tmr_cnt  = TW'(AUTO_INIT_CYC - POST_RESET_WAIT_CYC);
          end
        end
        D_AUTOINI: begin
          err_nxt = any_cmd && !is_mrr;
          if (tmr_done) begin
            st_nxt = D_IDLE;
          end
        end
        D_IDLE: begin
          if (is_mrw && (link.ca_addr == MR_CALIBRATION)) begin
            st_nxt   = D_CAL;
            tmr_load = 1'b1;
            tmr_cnt  = TW'(INITIAL_CAL_CYC);
          end
        end
        D_CAL: begin
          err_nxt = any_cmd && !is_mrr;
          if (tmr_done) begin
            st_nxt = D_READY;
          end
        end
        D_READY: begin
          st_nxt = D_READY;
        end
        default: begin
          st_nxt = D_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r    <= D_OFF;
      err_r   <= 1'b0;
      idle_r  <= 1'b0;
      ready_r <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      err_r   <= err_nxt;
      idle_r  <= (st_nxt == D_IDLE);
      ready_r <= (st_nxt == D_READY);
    end
  end

  // ------------------------------------------------------------
  // Auto-init flag and termination enable
  // ------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      flag_r <= 1'b1;
    end else if (is_rst) begin
      flag_r <= 1'b1;
    end else if (st_r == D_AUTOINI && tmr_done) begin
      flag_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || is_rst) begin
      term_r <= 1'b0;
    end else if (st_r == D_READY && is_mrw && link.ca_addr == MR_TERMINATION) begin
      term_r <= link.ca_op[TERM_ENABLE_BIT];
    end
  end

  // ------------------------------------------------------------
  // Mode register read answer
  // ------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      dq_r    <= 8'h00;
      dq_oe_r <= 1'b0;
    end else begin
      // Outputs stay released while clock enable is low
      dq_oe_r <= is_mrr && (st_r != D_POSTRST);
      if (is_mrr && link.ca_addr == MR_DEVICE_INFO) begin
        dq_r <= {7'h00, flag_r};
      end else begin
        dq_r <= 8'h00;
      end
    end
  end

  assign link.dq    = dq_r;
  assign link.dq_oe = dq_oe_r;

  assign o_idle           = idle_r;
  assign o_ready          = ready_r;
  assign o_auto_init_flag = flag_r;
  assign o_term_en        = term_r;
  assign o_cmd_err        = err_r;
  assign o_state          = st_r;
endmodule

//--- lpddr_init_ctrl.sv
// Controller end: power-up, reset, polling, calibration and mode setup sequencer
module lpddr_init_ctrl #(
  parameter int FIRST_IDLE_CYC = lpddr_init_pkg::FIRST_IDLE_WAIT_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic [31:0]      o_wb_dat,
  output logic             o_wb_ack,
  lpddr_link_if.ctrl       link
);
  import lpddr_init_pkg::*;

  typedef enum logic [3:0] {
    S_OFF     = 4'h0,
    S_CLKUP   = 4'h1,
    S_IDLE1   = 4'h3,
    S_PREA    = 4'h2,
    S_RESET   = 4'h6,
    S_POSTRST = 4'h7,
    S_AI      = 4'h5,
    S_TRAIN   = 4'h4,
    S_CAL     = 4'hC,
    S_CALW    = 4'hD,
    S_MR1     = 4'hF,
    S_MR2     = 4'hE,
    S_MR3     = 4'hA,
    S_TERMINATION_REGISTER    = 4'hB,
    S_DONE    = 4'h9
  } cstate_t;

  cstate_t       st_r;
  cstate_t       st_nxt;
  logic [6:0]    ctrl_r;
  logic [31:0]   mrcfg_r;
  logic          start_r;
  logic          ack_r;
  logic [31:0]   rdat_r;
  logic          wr_en;
  logic          ai_seen_r;
  logic          ai_tmo_r;
  logic          term_lvl_r;
  logic          ck_run_r;
  logic          cke_r;
  logic          ca_oe_r;
  ca_cmd_t       ca_cmd_r;
  logic [7:0]    ca_addr_r;
  logic [7:0]    ca_op_r;
  logic          issue;
  ca_cmd_t       cmd;
  logic [7:0]    addr;
  logic [7:0]    op;
  logic          tmr_load;
  logic [TW-1:0] tmr_cnt;
  logic          tmr_done;
  logic [2:0]    gap_r;
  logic          flag_clear;
  logic [31:0]   ctrl_wr;

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ------------------------------------------------------------
  // Wishbone slave
  // ------------------------------------------------------------
  assign wr_en   = i_wb_cyc && i_wb_stb && i_wb_we && ack_r;
  assign ctrl_wr = merge({25'h0, ctrl_r}, i_wb_dat, i_wb_sel);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r <= i_wb_cyc && i_wb_stb && !ack_r;
      case (i_wb_adr)
        REG_CTRL:   rdat_r <= {25'h0, ctrl_r};
        REG_MRCFG:  rdat_r <= mrcfg_r;
        REG_STATUS: rdat_r <= {26'h0, ai_tmo_r, ai_seen_r, (st_r == S_DONE), st_r[3:1]};
        default:    rdat_r <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_r  <= CTRL_RST;
      mrcfg_r <= MRCFG_RST;
      start_r <= 1'b0;
    end else begin
      start_r <= 1'b0;
      if (wr_en && i_wb_adr == REG_CTRL) begin
        ctrl_r  <= ctrl_wr[6:0] & ~7'h01;
        start_r <= i_wb_sel[0] && i_wb_dat[CTRL_START];
      end
      if (wr_en && i_wb_adr == REG_MRCFG) begin
        mrcfg_r <= merge(mrcfg_r, i_wb_dat, i_wb_sel);
      end
    end
  end

  lpddr_cycle_timer #(.W(TW)) u_tmr (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_load  (tmr_load),
    .i_count (tmr_cnt),
    .o_done  (tmr_done)
  );

  assign flag_clear = link.dq_oe && !link.dq[AUTO_INIT_FLAG_BIT];

  // ------------------------------------------------------------
  // Sequence state and command choice
  // ------------------------------------------------------------
  always_comb begin
    st_nxt   = st_r;
    issue    = 1'b0;
    cmd      = CMD_NOP;
    addr     = 8'h00;
    op       = 8'h00;
    tmr_load = 1'b0;
    tmr_cnt  = '0;
    case (st_r)
      S_OFF: begin
        if (start_r) begin
          st_nxt   = S_CLKUP;
          tmr_load = 1'b1;
          tmr_cnt  = TW'(CLKUP_WAIT_CYC);
        end
      end
      S_CLKUP: begin
        if (tmr_done) begin
          st_nxt   = S_IDLE1;
          tmr_load = 1'b1;
          tmr_cnt  = TW'(FIRST_IDLE_CYC);
        end
      end
      S_IDLE1: begin
        if (tmr_done) begin
          st_nxt = S_PREA;
        end
      end
      S_PREA: begin
        st_nxt = S_RESET;
        issue  = ctrl_r[CTRL_PREA];
        cmd    = CMD_PREA;
      end
      S_RESET: begin
        st_nxt   = S_POSTRST;
        issue    = 1'b1;
        cmd      = CMD_MRW;
        addr     = MR_RESET;
        tmr_load = 1'b1;
        tmr_cnt  = TW'(POST_RESET_WAIT_CYC);
      end
      S_POSTRST: begin
        if (tmr_done) begin
          st_nxt   = S_AI;
          tmr_load = 1'b1;
          tmr_cnt  = TW'(AUTO_INIT_MAX_CYC - POST_RESET_WAIT_CYC);
        end
      end
      S_AI: begin
        // Reads spaced at the boot clock period, only without training
        if (ctrl_r[CTRL_POLL] && !ctrl_r[CTRL_TRAIN] && gap_r == 3'h0) begin
          issue = 1'b1;
          cmd   = CMD_MRR;
          addr  = MR_DEVICE_INFO;
        end
        if (tmr_done || (flag_clear && ctrl_r[CTRL_POLL])) begin
          issue  = 1'b0;
          st_nxt = ctrl_r[CTRL_TRAIN] ? S_TRAIN : S_CAL;
        end
      end
      S_TRAIN: begin
        if (ctrl_r[CTRL_TRAINED]) begin
          st_nxt = S_CAL;
        end
      end
      S_CAL: begin
        st_nxt   = S_CALW;
        issue    = 1'b1;
        cmd      = CMD_MRW;
        addr     = MR_CALIBRATION;
        op       = CAL_INIT_CODE;
        tmr_load = 1'b1;
        tmr_cnt  = TW'(INITIAL_CAL_CYC);
      end
      S_CALW: begin
        if (tmr_done) begin
          st_nxt = S_MR1;
        end
      end
      S_MR1: begin
        st_nxt = S_MR2;
        issue  = 1'b1;
        cmd    = CMD_MRW;
        addr   = MR_FEATURE1;
        op     = mrcfg_r[7:0];
      end
      S_MR2: begin
        st_nxt = S_MR3;
        issue  = 1'b1;
        cmd    = CMD_MRW;
        addr   = MR_FEATURE2;
        op     = mrcfg_r[15:8];
      end
      S_MR3: begin
        st_nxt = S_TERMINATION_REGISTER;
        issue  = 1'b1;
        cmd    = CMD_MRW;
        addr   = MR_IO_CONFIG;
        op     = mrcfg_r[23:16];
      end
      S_TERMINATION_REGISTER: begin
        st_nxt = S_DONE;
        issue  = 1'b1;
        cmd    = CMD_MRW;
        addr   = MR_TERMINATION;
        op     = mrcfg_r[31:24];
      end
      S_DONE: begin
        if (start_r) begin
          st_nxt = S_PREA;
        end
      end
      default: begin
        st_nxt = S_OFF;
      end
    endcase
    if (ctrl_r[CTRL_PWROFF]) begin
      st_nxt = S_OFF;
      issue  = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r <= S_OFF;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || st_r != S_AI) begin
      gap_r <= 3'h0;
    end else if (issue) begin
      gap_r <= 3'(BOOT_CMD_SPACING_CYC - 1);
    end else if (gap_r != 3'h0) begin
      gap_r <= gap_r - 3'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || st_r == S_RESET) begin
      ai_seen_r <= 1'b0;
      ai_tmo_r  <= 1'b0;
    end else if (st_r == S_AI) begin
      ai_seen_r <= ai_seen_r || flag_clear;
      ai_tmo_r  <= ai_tmo_r || tmr_done;
    end
  end

  // ------------------------------------------------------------
  // Link pins
  // ------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ck_run_r   <= 1'b0;
      cke_r      <= 1'b0;
      term_lvl_r <= 1'b0;
    end else begin
      ck_run_r <= (st_nxt != S_OFF);
      cke_r    <= (st_nxt != S_OFF) && (st_nxt != S_CLKUP);
      if (st_r == S_OFF && start_r) begin
        term_lvl_r <= ctrl_r[CTRL_TERMLVL];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ca_oe_r   <= 1'b0;
      ca_cmd_r  <= CMD_NOP;
      ca_addr_r <= 8'h00;
      ca_op_r   <= 8'h00;
    end else begin
      ca_oe_r   <= issue;
      ca_cmd_r  <= issue ? cmd : CMD_NOP;
      ca_addr_r <= addr;
      ca_op_r   <= op;
    end
  end

  assign link.ck_run   = ck_run_r;
  assign link.cke      = cke_r;
  assign link.term_ctl = term_lvl_r;
  assign link.ca_oe    = ca_oe_r;
  assign link.ca_cmd   = ca_cmd_r;
  assign link.ca_addr  = ca_addr_r;
  assign link.ca_op    = ca_op_r;
  assign o_wb_dat      = rdat_r;
  assign o_wb_ack      = ack_r;
endmodule

//--- lpddr_init_asserts.sv
// Link checker for the controller and device init sequencer pair
module lpddr_init_asserts #(
  parameter int FIRST_IDLE_CYC = lpddr_init_pkg::FIRST_IDLE_WAIT_CYC
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_rst,
  input  wire logic                    ck_run,
  input  wire logic                    cke,
  input  wire logic                    term_ctl,
  input  wire logic                    ca_oe,
  input  wire lpddr_init_pkg::ca_cmd_t ca_cmd,
  input  wire logic [7:0]              ca_addr,
  input  wire logic [7:0]              ca_op,
  input  wire logic [7:0]              dq,
  input  wire logic                    dq_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  import lpddr_init_pkg::*;

  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  logic        rd_q;
  logic        last_rst;
  logic        last_cal;
  logic [31:0] cke_cnt;
  logic [31:0] gap_cnt;
  wire logic   mode_reg_read = ca_oe && ca_cmd == CMD_MRR;
  wire logic   mode_reg_write = ca_oe && ca_cmd == CMD_MRW;

  always_ff @(posedge i_clk) begin
    if (i_rst) rd_q <= 1'b0;
    else rd_q <= mode_reg_read;
  end

  // Kind of the last command sent
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      last_rst <= 1'b0;
      last_cal <= 1'b0;
    end else if (ca_oe) begin
      last_rst <= mode_reg_write && ca_addr == MR_RESET;
      last_cal <= mode_reg_write && ca_addr == MR_CALIBRATION;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || !cke) cke_cnt <= 32'h0;
    else cke_cnt <= cke_cnt + 32'h1;
  end

  // Idle cycles since the last command
  always_ff @(posedge i_clk) begin
    if (i_rst || ca_oe) gap_cnt <= 32'h0;
    else gap_cnt <= gap_cnt + 32'h1;
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_first_idle_wait: assert property (ca_oe |-> cke_cnt >= FIRST_IDLE_CYC)
    else $error("command before first idle wait");
  a_cmd_needs_clock: assert property (ca_oe |-> cke && ck_run)
    else $error("command without clock enable");
  a_post_reset_gap: assert property (ca_oe && last_rst |-> gap_cnt >= POST_RESET_WAIT_CYC - 1)
    else $error("command too soon after reset");
  a_cal_time_gap: assert property (ca_oe && last_cal |-> gap_cnt >= INITIAL_CAL_CYC - 1)
    else $error("command too soon after calibration");
  a_read_spacing: assert property (mode_reg_read |=> (!mode_reg_read) [*3])
    else $error("reads closer than boot period");
  a_read_answered: assert property (mode_reg_read |=> dq_oe)
    else $error("read not answered");
  a_answer_cause: assert property (dq_oe |-> rd_q)
    else $error("data driven without read");
  a_flag_field: assert property (dq_oe |-> dq[7:1] == 7'h00)
    else $error("flag not alone in bit zero");
  a_term_static: assert property (cke && $past(cke) |-> $stable(term_ctl))
    else $error("termination input moved");
  a_clock_first: assert property ($rose(cke) |-> $past(ck_run, 5))
    else $error("clock enable before stable clock");
  a_off_quiet: assert property (!cke |-> !ca_oe && !dq_oe)
    else $error("activity with clock enable low");

  c_reset_cmd: cover property (mode_reg_write && ca_addr == MR_RESET);
  c_flag_clear: cover property (dq_oe && !dq[0]);
  c_cal_cmd: cover property (mode_reg_write && ca_addr == MR_CALIBRATION);
endmodule

//--- lpddr_init_sequence_bench.sv
// Bench joining controller and device ends over the link
module lpddr_init_sequence_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import lpddr_init_pkg::*;
  localparam int IDLE = 50;

  logic        i_clk;
  logic        i_rst = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] wdat  = 32'h0;
  logic [3:0]  sel   = 4'h0;
  logic [3:0]  lanes = 4'hF;
  logic        idle;
  logic [31:0] rdat;
  logic [31:0] got;
  logic        ack;
  logic        ready;
  logic        flag;
  logic        term_en;
  logic        cmd_err;
  logic        watch = 1'b0;
  logic        cke_fell = 1'b0;
  int          bad_count = 0;
  int          n_compared = 0;
  int          n_err = 0;
  int          cyc_n = 0;
  int          t_rst = 0;
  int          t_flag = 0;

  lpddr_link_if link();
  lpddr_init_ctrl #(.FIRST_IDLE_CYC(IDLE)) i_lpddr_init_ctrl (.i_clk(i_clk), .i_rst(i_rst),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .link(link));
  lpddr_init_mem i_lpddr_init_mem (.i_clk(i_clk), .i_rst(i_rst), .link(link), .o_idle(idle),
    .o_ready(ready), .o_auto_init_flag(flag), .o_term_en(term_en), .o_cmd_err(cmd_err),
    .o_state());
  lpddr_init_asserts #(.FIRST_IDLE_CYC(IDLE)) i_lpddr_init_asserts (.i_clk(i_clk),
    .i_rst(i_rst), .ck_run(link.ck_run), .cke(link.cke), .term_ctl(link.term_ctl),
    .ca_oe(link.ca_oe), .ca_cmd(link.ca_cmd), .ca_addr(link.ca_addr), .ca_op(link.ca_op),
    .dq(link.dq), .dq_oe(link.dq_oe));

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // ----------------------------------------
  // Link monitor
  // ----------------------------------------
  always @(posedge i_clk) begin
    cyc_n <= cyc_n + 1;
    if (cmd_err === 1'b1) n_err <= n_err + 1;
    if (link.ca_oe && link.ca_cmd == CMD_MRW && link.ca_addr == MR_RESET) t_rst <= cyc_n;
    if (flag === 1'b0 && t_flag < t_rst) t_flag <= cyc_n;
    if (watch && link.cke !== 1'b1) cke_fell <= 1'b1;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic note(input string m);
    bad_count++;
    $display("unexpected at %0t: %s", $time, m);
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_compared++;
    if (g !== e) note(m);
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= lanes;
    wdat <= d;
    do begin
      @(posedge i_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      note("no ack");
      results();
    end
    got = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    do begin
      wb(1'b0, REG_STATUS, 32'h0);
      n++;
    end while (got[3] !== 1'b1 && n < 1000);
    if (got[3] !== 1'b1) begin
      note("sequence timeout");
      results();
    end
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    wb(1'b0, REG_CTRL, 32'h0);
    chk(got, {25'h0, CTRL_RST}, "ctrl reset");
    wb(1'b0, REG_MRCFG, 32'h0);
    chk(got, MRCFG_RST, "mrcfg reset");
    wb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    wb(1'b0, 8'h0C, 32'h0);
    chk(got, 32'h0, "unmapped");
    lanes = 4'h2;
    wb(1'b1, REG_MRCFG, 32'hFFFF_FFFF);
    lanes = 4'hF;
    wb(1'b0, REG_MRCFG, 32'h0);
    chk(got, 32'h0000_FF00, "byte lanes");
    chk(flag, 1'b1, "flag reset");
    chk(term_en, 1'b0, "term reset");
    chk(link.cke, 1'b0, "cke reset");
    wb(1'b1, REG_MRCFG, 32'h0133_2211);
    wb(1'b1, REG_CTRL, 32'h71);
    wait_done();
    chk(link.term_ctl, 1'b1, "term level");
    chk(flag, 1'b0, "flag clear");
    chk(t_flag - t_rst <= AUTO_INIT_MAX_CYC, 1'b1, "auto-init late");
    chk(ready, 1'b1, "not ready");
    chk(term_en, 1'b1, "termination off");
    chk(got[5:3], 3'b011, "poll status");
    watch <= 1'b1;
    wb(1'b1, REG_CTRL, 32'h03);
    repeat (2500) @(posedge i_clk);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(got[3], 1'b0, "done before training");
    chk(flag, 1'b0, "not idle after max");
    chk(idle, 1'b1, "device not idle");
    chk(ready, 1'b0, "ready before calibration");
    chk(term_en, 1'b0, "termination kept");
    wb(1'b1, REG_CTRL, 32'h06);
    wait_done();
    chk(got[5], 1'b1, "max wait not used");
    chk(ready, 1'b1, "not ready again");
    chk(cke_fell, 1'b0, "cke dropped on restart");
    watch <= 1'b0;
    wb(1'b1, REG_CTRL, 32'h08);
    repeat (2) @(posedge i_clk);
    chk(link.cke, 1'b0, "cke in power-off");
    chk(link.ck_run, 1'b0, "clock in power-off");
    chk(link.dq_oe, 1'b0, "dq in power-off");
    chk(n_err, 0, "device command errors");
    results();
  end
endmodule
